// [pkg/sac_pkg.sv]
// constants, register layouts and types of the automatic transfer controller
package sac_pkg;
	// register addresses on the memory bus
	localparam logic [15:0] ADDR_CTRL = 16'hFF69;
	localparam logic [15:0] ADDR_SHIFT = 16'hFF6A;
	localparam logic [15:0] ADDR_INTV = 16'hFF6B;
	// reset values
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [7:0] INTV_RST = 8'h00;
	// field positions of the hardware-owned control bits
	localparam int FAULT_BIT = 4;
	localparam int PROG_BIT = 3;
	// writable bits: control loses 4 and 3, interval loses 6 and 5
	localparam logic [7:0] CTRL_WMASK = 8'hE7;
	localparam logic [7:0] INTV_WMASK = 8'h9F;
	// gap timing in system clocks, and the floor in serial clocks
	localparam int GAP_UNIT_CYC = 128;
	localparam int GAP_BASE_CYC = 56;
	localparam int MIN_IDLE_SCK = 2;
	localparam int BYTE_BITS = 8;
	localparam int GAP_W = 13;
	// control register layout, bit 7 first
	typedef struct packed {
		logic inbound_enable;
		logic auto_repeat_select;
		logic fault_check_enable;
		logic fault;
		logic in_progress;
		logic strobe_output_enable;
		logic busy_input_enable;
		logic busy_polarity;
	} sac_ctrl_t;
	// interval register layout
	typedef struct packed {
		logic interval_control_enable;
		logic [1:0] zero;
		logic [4:0] interval_value;
	} sac_intv_t;
	// one memory bus access
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} sac_bus_t;
	// byte sequencer states
	typedef enum logic [1:0] {S_IDLE, S_SEND, S_GAP, S_BUSYW} sac_state_t;
endpackage : sac_pkg

// [src/sac_auto_txrx.sv]
// byte fifo and the automatic transmit/receive controller
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////
module sac_fifo #(
	parameter int W = 8,
	parameter int D = 8
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// fill side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [W-1:0] in_data_i,
	// drain side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [W-1:0] out_data_o
);
	localparam int AW = $clog2(D);
	// pointer arithmetic needs a power-of-two depth
	if (D < 2 || (D & (D - 1)) != 0) begin : g_bad_depth
		$error("sac_fifo depth must be a power of two");
	end
	logic [W-1:0] mem_ff [D];
	logic [AW:0] wptr_ff;
	logic [AW:0] rptr_ff;
	wire empty = (wptr_ff == rptr_ff);
	wire full = (wptr_ff[AW-1:0] == rptr_ff[AW-1:0]) && (wptr_ff[AW] != rptr_ff[AW]);
	wire push = in_valid_i && !full;
	wire pop = out_ready_i && !empty;
	assign in_ready_o = !full;
	assign out_valid_o = !empty;
	assign out_data_o = mem_ff[rptr_ff[AW-1:0]];
	// pointers
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wptr_ff <= '0;
			rptr_ff <= '0;
		end else begin
			if (push) wptr_ff <= wptr_ff + 1'b1;
			if (pop) rptr_ff <= rptr_ff + 1'b1;
		end
	end
	// storage, one flip-flop word per entry
	for (genvar i = 0; i < D; i++) begin : g_mem
		always_ff @(posedge clk_i or negedge rst_n_i) begin
			if (!rst_n_i) mem_ff[i] <= '0;
			else if (push && wptr_ff[AW-1:0] == AW'(i)) mem_ff[i] <= in_data_i;
		end
	end
endmodule : sac_fifo

////////////////////////////////////////////////////////////////////////
// What this block does
// - fault check only when busy input enabled
// - repeat select picks single or repeated mode
// - inbound enable gates received data capture
// - fault and in-progress bits ignore writes
// - interval enable spaces bytes by value
// - gap is (n+1)*128 plus 56 clocks
// - gap never below two serial clocks
// - interval control disables busy handshake
// - interval register resets to zero
// - in-progress set on shift write, cleared at end
// - fault cleared on shift write, set on error
// - control register resets to zero
module sac_auto_txrx
	import sac_pkg::*;
#(
	parameter int GAP_UNIT = GAP_UNIT_CYC,
	parameter int DEPTH = 8
) (
	// system clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// memory bus
	input wire sac_bus_t bus_i,
	output logic [7:0] rdata_o,
	output logic tx_ready_o,
	// serial link
	input wire logic sclk_i,
	output logic so_o,
	input wire logic si_i,
	input wire logic busy_i,
	output logic strobe_o
);
	// the gap counter is sized for the documented unit only
	if (GAP_UNIT < 1 || GAP_UNIT > GAP_UNIT_CYC) begin : g_bad_unit
		$error("sac_auto_txrx gap unit out of range");
	end

	////////////////////////////////////////////////////////////////////
	// registers and decode
	sac_ctrl_t ctrl_ff;
	sac_intv_t intv_ff;
	logic fault_ff;
	logic prog_ff;
	logic [7:0] rx_ff, lrx_ff;
	logic [7:0] tx_ff;
	logic [7:0] rdata_ff;
	logic strobe_ff;
	logic req_ff;
	logic seen_ff;
	logic [GAP_W-1:0] gap_ff;
	sac_state_t state_ff;
	logic ack_s1_ff, ack_s2_ff, ack_s3_ff, lack_ff;
	logic busy_s1_ff, busy_s2_ff;
	logic fifo_valid;
	logic fifo_in_ready;
	logic [7:0] fifo_data;

	wire wr_ctrl = bus_i.wr && bus_i.addr == ADDR_CTRL;
	wire wr_intv = bus_i.wr && bus_i.addr == ADDR_INTV;
	wire wr_shift = bus_i.wr && bus_i.addr == ADDR_SHIFT;
	wire ack_evt = ack_s2_ff ^ ack_s3_ff;
	wire busy_act = busy_s2_ff ^ ctrl_ff.busy_polarity;
	wire check_on = ctrl_ff.fault_check_enable && ctrl_ff.busy_input_enable;
	wire int_on = intv_ff.interval_control_enable;
	wire byte_done = state_ff == S_SEND && ack_evt;
	wire fault_evt = byte_done && check_on && !seen_ff;
	wire recirc = byte_done && ctrl_ff.auto_repeat_select;
	wire sw_push = wr_shift && fifo_in_ready && !recirc;
	wire pop = state_ff == S_IDLE && prog_ff && fifo_valid;
	wire seq_end = state_ff == S_IDLE && prog_ff && !fifo_valid;
	wire [GAP_W-1:0] gap_load = int_on ?
		GAP_W'((32'(intv_ff.interval_value) + 1) * GAP_UNIT + GAP_BASE_CYC - 1) :
		'0;
	wire [7:0] ctrl_rd = {ctrl_ff[7:5], fault_ff, prog_ff, ctrl_ff[2:0]};
	wire [7:0] rd_mux = bus_i.addr == ADDR_CTRL ? ctrl_rd :
		bus_i.addr == ADDR_INTV ? 8'(intv_ff) :
		bus_i.addr == ADDR_SHIFT ? rx_ff : 8'h00;
	assign rdata_o = rdata_ff;
	assign strobe_o = strobe_ff;
	assign tx_ready_o = fifo_in_ready && !recirc;

	// software registers; hardware bits live apart so writes miss them
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ctrl_ff <= CTRL_RST;
			intv_ff <= INTV_RST;
			rdata_ff <= 8'h00;
		end else begin
			if (wr_ctrl) ctrl_ff <= bus_i.wdata & CTRL_WMASK;
			if (wr_intv) intv_ff <= bus_i.wdata & INTV_WMASK;
			if (bus_i.rd) rdata_ff <= rd_mux;
		end
	end

	// in-progress and fault: the start write wins over any clear, a fault set wins over the start write
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prog_ff <= CTRL_RST[PROG_BIT];
			fault_ff <= CTRL_RST[FAULT_BIT];
		end else begin
			if (sw_push) prog_ff <= 1'b1;
			else if (seq_end || fault_evt) prog_ff <= 1'b0;
			if (fault_evt) fault_ff <= 1'b1;
			else if (sw_push) fault_ff <= 1'b0;
		end
	end

	// busy pin and ack toggle enter through two flip-flops
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			busy_s1_ff <= 1'b0;
			busy_s2_ff <= 1'b0;
			ack_s1_ff <= 1'b0;
			ack_s2_ff <= 1'b0;
			ack_s3_ff <= 1'b0;
		end else begin
			busy_s1_ff <= busy_i;
			busy_s2_ff <= busy_s1_ff;
			ack_s1_ff <= lack_ff;
			ack_s2_ff <= ack_s1_ff;
			ack_s3_ff <= ack_s2_ff;
		end
	end

	// byte sequencer; tx_ff holds still until the link acknowledges
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_ff <= S_IDLE;
			tx_ff <= 8'h00;
			req_ff <= 1'b0;
			seen_ff <= 1'b0;
			gap_ff <= '0;
			rx_ff <= 8'h00;
			strobe_ff <= 1'b0;
		end else begin
			strobe_ff <= byte_done && ctrl_ff.strobe_output_enable;
			case (state_ff)
				S_IDLE: if (pop) begin
					tx_ff <= fifo_data;
					req_ff <= !req_ff;
					seen_ff <= 1'b0;
					state_ff <= S_SEND;
				end
				S_SEND: begin
					if (busy_act) seen_ff <= 1'b1;
					if (ack_evt) begin
						if (ctrl_ff.inbound_enable) rx_ff <= lrx_ff;
						gap_ff <= gap_load;
						state_ff <= fault_evt ? S_IDLE : S_GAP;
					end
				end
				S_GAP: begin
					if (gap_ff == '0) state_ff <= S_BUSYW;
					else gap_ff <= gap_ff - 1'b1;
				end
				S_BUSYW: begin
					// interval timing overrides the busy wait
					if (int_on || !ctrl_ff.busy_input_enable || !busy_act)
						state_ff <= S_IDLE;
				end
				default: state_ff <= S_IDLE;
			endcase
		end
	end

	// repeated mode feeds each sent byte back into the queue
	sac_fifo #(.W(8), .D(DEPTH)) u_fifo (
		.clk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.in_valid_i(recirc || sw_push),
		.in_ready_o(fifo_in_ready),
		.in_data_i(recirc ? tx_ff : bus_i.wdata),
		.out_valid_o(fifo_valid),
		.out_ready_i(pop),
		.out_data_o(fifo_data)
	);

	////////////////////////////////////////////////////////////////////
	// link domain on the serial clock
	logic lreq_s1_ff, lreq_s2_ff;
	logic lbusy_ff;
	logic [3:0] lcnt_ff;
	logic [7:0] lsh_ff;
	logic [1:0] lidle_ff;
	logic so_ff;
	wire lpend = lreq_s2_ff ^ lack_ff;
	wire lstart = lpend && !lbusy_ff && lidle_ff >= 2'(MIN_IDLE_SCK);
	assign so_o = so_ff;

	// request toggle crossing
	always_ff @(posedge sclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			lreq_s1_ff <= 1'b0;
			lreq_s2_ff <= 1'b0;
		end else begin
			lreq_s1_ff <= req_ff;
			lreq_s2_ff <= lreq_s1_ff;
		end
	end

	// shifter; idle count holds off the next byte for two clocks
	always_ff @(posedge sclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			lack_ff <= 1'b0;
			lbusy_ff <= 1'b0;
			lcnt_ff <= 4'h0;
			lsh_ff <= 8'h00;
			lrx_ff <= 8'h00;
			lidle_ff <= 2'(MIN_IDLE_SCK);
			so_ff <= 1'b1;
		end else if (lstart) begin
			lsh_ff <= tx_ff;
			so_ff <= tx_ff[7];
			lcnt_ff <= 4'(BYTE_BITS);
			lbusy_ff <= 1'b1;
			lidle_ff <= 2'h0;
		end else if (lbusy_ff) begin
			lsh_ff <= {lsh_ff[6:0], si_i};
			if (lcnt_ff != 4'h1) so_ff <= lsh_ff[6]; // bit 0 stands after the byte
			lcnt_ff <= lcnt_ff - 1'b1;
			if (lcnt_ff == 4'h1) begin
				lbusy_ff <= 1'b0;
				lrx_ff <= {lsh_ff[6:0], si_i};
				lack_ff <= !lack_ff;
			end
		end else if (lidle_ff < 2'(MIN_IDLE_SCK)) begin
			lidle_ff <= lidle_ff + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////
	// checks
	property p_ro_bits;
		@(posedge mclk_i) disable iff (!rst_n_i)
		wr_ctrl && !sw_push && !fault_evt && !seq_end
			|=> $stable(fault_ff) && $stable(prog_ff);
	endproperty
	a_ro_bits: assert property (p_ro_bits) else $error("hw bit moved on write");
	property p_start;
		@(posedge mclk_i) disable iff (!rst_n_i)
		sw_push && !fault_evt |=> prog_ff && !fault_ff;
	endproperty
	a_start: assert property (p_start) else $error("start write not taken");
	property p_fault_cause;
		@(posedge mclk_i) disable iff (!rst_n_i)
		$rose(fault_ff) |-> $past(check_on) && $past(state_ff == S_SEND);
	endproperty
	a_fault_cause: assert property (p_fault_cause) else $error("fault without check");
	property p_no_fault;
		@(posedge mclk_i) disable iff (!rst_n_i)
		!ctrl_ff.busy_input_enable && !wr_ctrl |=> !$rose(fault_ff);
	endproperty
	a_no_fault: assert property (p_no_fault) else $error("fault with busy off");
	property p_gap_min;
		@(posedge mclk_i) disable iff (!rst_n_i)
		byte_done && int_on && !fault_evt |=> (state_ff == S_GAP) [*8];
	endproperty
	a_gap_min: assert property (p_gap_min) else $error("gap too short");
	property p_busy_skip;
		@(posedge mclk_i) disable iff (!rst_n_i)
		state_ff == S_BUSYW && int_on |=> state_ff == S_IDLE;
	endproperty
	a_busy_skip: assert property (p_busy_skip) else $error("busy wait under interval");
	property p_rx_gate;
		@(posedge mclk_i) disable iff (!rst_n_i)
		byte_done && !ctrl_ff.inbound_enable |=> $stable(rx_ff);
	endproperty
	a_rx_gate: assert property (p_rx_gate) else $error("rx taken while disabled");
	property p_single;
		@(posedge mclk_i) disable iff (!rst_n_i)
		byte_done && !ctrl_ff.auto_repeat_select && !wr_shift && !fifo_valid |=> !fifo_valid;
	endproperty
	a_single: assert property (p_single) else $error("requeue in single mode");
	property p_idle_floor;
		@(posedge sclk_i) disable iff (!rst_n_i)
		$fell(lbusy_ff) |-> !lbusy_ff [*2];
	endproperty
	a_idle_floor: assert property (p_idle_floor) else $error("link gap under two");
endmodule : sac_auto_txrx

// [verif/sac_peer.sv]
// serial peripheral model: drives the data-in line and the busy pin
`timescale 1ns/1ns
module sac_peer (
	// link clock and reset
	input wire logic sclk_i,
	input wire logic rst_n_i,
	// bench control: busy 0 never, 1 short pulses, 2 held; data-in level
	input wire logic [1:0] busy_mode_i,
	input wire logic si_lvl_i,
	// pins toward the block
	output logic si_o,
	output logic busy_o
);
	logic [2:0] cnt_ff;
	// free count of link clocks
	always_ff @(posedge sclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_ff <= 3'h0;
		end else begin
			cnt_ff <= cnt_ff + 3'h1;
		end
	end
	// two edges in eight: every byte sees busy, yet a busy wait ends fast
	assign busy_o = (busy_mode_i == 2'h2) | ((busy_mode_i == 2'h1) & (cnt_ff < 3'h2));
	// a steady level makes the received byte independent of frame phase
	assign si_o = si_lvl_i;
endmodule : sac_peer

// [verif/sac_auto_txrx_tb.sv]
// self-checking bench of the automatic transmit/receive controller
`timescale 1ns/1ns
module sac_auto_txrx_tb
	import sac_pkg::*;
;
	logic mclk_i = 1'b0;
	logic sclk_i = 1'b0;
	logic rst_n_i = 1'b1;
	sac_bus_t bus_i = '0;
	logic [7:0] rdata_o;
	logic tx_ready_o;
	logic so_o;
	logic si_i;
	logic busy_i;
	logic strobe_o;
	logic [1:0] busy_mode = 2'h0;
	logic si_lvl = 1'b1;
	logic [7:0] rv;
	int num_errors = 0;
	int tests_run = 0;
	int cyc = 0;
	int tstb[$];
	localparam int LO = 2 * GAP_UNIT_CYC + GAP_BASE_CYC + 100;

	////////////////////////////////////////////////////////////////////////
	// system clock, and an unrelated 125 ns link clock
	always #5 mclk_i = ~mclk_i;
	initial begin
		#37;
		forever begin
			#62 sclk_i = 1'b1;
			#63 sclk_i = 1'b0;
		end
	end
	// strobe times in system cycles
	always @(posedge mclk_i) begin
		cyc <= cyc + 1;
		if (strobe_o === 1'b1) begin
			tstb.push_back(cyc);
		end
	end

	sac_auto_txrx u_sac_auto_txrx (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .bus_i(bus_i),
		.rdata_o(rdata_o), .tx_ready_o(tx_ready_o), .sclk_i(sclk_i), .so_o(so_o),
		.si_i(si_i), .busy_i(busy_i), .strobe_o(strobe_o));
	sac_peer u_sac_peer (.sclk_i(sclk_i), .rst_n_i(rst_n_i), .busy_mode_i(busy_mode),
		.si_lvl_i(si_lvl), .si_o(si_i), .busy_o(busy_i));

	////////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			num_errors++;
			$display("mismatch %s expected %0h seen %0h", what, exp, seen);
		end
	endtask : check
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge mclk_i);
		bus_i <= '0;
	endtask : wr
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(posedge mclk_i);
		bus_i <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge mclk_i);
		bus_i <= '0;
		@(posedge mclk_i);
		#1 d = rdata_o;
	endtask : rd
	// polling the in-progress flag, since the per-byte flag says nothing of the end
	task automatic wait_idle();
		int n;
		n = 0;
		rv = 8'hFF;
		while (rv[PROG_BIT] !== 1'b0 && n < 4000) begin
			rd(ADDR_CTRL, rv);
			n++;
		end
		check("idle", {31'h0, rv[PROG_BIT]}, 32'h0);
	endtask : wait_idle
	task automatic rd_chk(input string what, input logic [15:0] a, input logic [7:0] exp);
		rd(a, rv);
		check(what, rv, exp);
	endtask : rd_chk

	////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		rd_chk("ctrl rst", ADDR_CTRL, CTRL_RST);
		rd_chk("intv rst", ADDR_INTV, INTV_RST);
		rd_chk("unmapped", 16'hFF00, 8'h00);
		wr(ADDR_CTRL, 8'hFF);
		rd_chk("ctrl ro", ADDR_CTRL, 8'hE7);
	endtask : t_reset
	task automatic t_single();
		wr(ADDR_CTRL, 8'h80);
		wr(ADDR_SHIFT, 8'hA5);
		rd_chk("prog set", ADDR_CTRL, 8'h88);
		wait_idle();
		rd_chk("rx on", ADDR_SHIFT, 8'hFF);
		@(posedge mclk_i) si_lvl <= 1'b0;
		wr(ADDR_CTRL, 8'h00);
		wr(ADDR_SHIFT, 8'h3C);
		wait_idle();
		rd_chk("rx off", ADDR_SHIFT, 8'hFF);
	endtask : t_single
	// busy held high must not stall bytes spaced by the interval
	task automatic t_gap();
		int d;
		wr(ADDR_CTRL, 8'h06);
		@(posedge mclk_i) busy_mode <= 2'h2;
		wr(ADDR_INTV, 8'h81);
		tstb.delete();
		wr(ADDR_SHIFT, 8'h11);
		wr(ADDR_SHIFT, 8'h22);
		wait_idle();
		d = tstb[1] - tstb[0];
		check("gap on", 32'(d >= LO && d <= LO + 108), 32'h1);
		@(posedge mclk_i) busy_mode <= 2'h0;
		wr(ADDR_INTV, 8'h00);
		tstb.delete();
		wr(ADDR_SHIFT, 8'h11);
		wr(ADDR_SHIFT, 8'h22);
		wait_idle();
		d = tstb[1] - tstb[0];
		check("gap off", 32'(tstb.size() == 2 && d < LO), 32'h1);
	endtask : t_gap
	task automatic t_fault();
		wr(ADDR_CTRL, 8'h22);
		wr(ADDR_SHIFT, 8'h5A);
		wait_idle();
		rd_chk("fault set", ADDR_CTRL, 8'h32);
		@(posedge mclk_i) busy_mode <= 2'h1;
		wr(ADDR_SHIFT, 8'h5A);
		rd_chk("fault clr", ADDR_CTRL, 8'h2A);
		wait_idle();
		rd_chk("no fault", ADDR_CTRL, 8'h22);
		@(posedge mclk_i) busy_mode <= 2'h0;
		wr(ADDR_CTRL, 8'h20);
		wr(ADDR_SHIFT, 8'h5A);
		wait_idle();
		rd_chk("no check", ADDR_CTRL, 8'h20);
	endtask : t_fault
	task automatic t_repeat();
		wr(ADDR_CTRL, 8'h40);
		wr(ADDR_SHIFT, 8'h77);
		repeat (3000) @(posedge mclk_i);
		rd_chk("repeat", ADDR_CTRL, 8'h48);
		wr(ADDR_CTRL, 8'h00);
		wait_idle();
		check("so idle", {31'h0, so_o}, 32'h1);
	endtask : t_repeat
	// a peer held busy stalls the sequencer until the fifo refuses
	task automatic t_fill();
		wr(ADDR_CTRL, 8'h02);
		@(posedge mclk_i) busy_mode <= 2'h2;
		repeat (11) wr(ADDR_SHIFT, 8'hC3);
		#1 check("full", {31'h0, tx_ready_o}, 32'h0);
		@(posedge mclk_i) busy_mode <= 2'h0;
		wait_idle();
		check("drained", {31'h0, tx_ready_o}, 32'h1);
		check("so last", {31'h0, so_o}, 32'h1);
	endtask : t_fill

	////////////////////////////////////////////////////////////////////////
	task automatic finish_test();
		$display("checks %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : finish_test
	// reset falls at time zero so both domains clear without waiting for a link edge
	initial begin
		rst_n_i <= 1'b0;
		repeat (8) @(posedge mclk_i);
		rst_n_i <= 1'b1;
		t_reset();
		t_single();
		t_gap();
		t_fault();
		t_repeat();
		t_fill();
		finish_test();
	end
	// watchdog well past the expected run
	initial begin
		#900000;
		num_errors++;
		finish_test();
	end
endmodule : sac_auto_txrx_tb
